/* File: include/tcc_pkg.sv */
/*
 Package for the capture/compare timer: register offsets, field
 positions, reset values and mode encodings.
 Assumes a 12-bit byte register address space.
*/
package tcc_pkg;
    localparam logic [11:0] TCC_ADDR_COUNT_HI = 12'hF00;
    localparam logic [11:0] TCC_ADDR_COUNT_LO = 12'hF01;
    localparam logic [11:0] TCC_ADDR_RELOAD_HI = 12'hF02;
    localparam logic [11:0] TCC_ADDR_RELOAD_LO = 12'hF03;
    localparam logic [11:0] TCC_ADDR_CAPTURE_HI = 12'hF04;
    localparam logic [11:0] TCC_ADDR_CAPTURE_LO = 12'hF05;
    localparam logic [11:0] TCC_ADDR_CONTROL = 12'hF06;
    localparam logic [11:0] TCC_ADDR_CONTROL_ONE = 12'hF07;

    localparam logic [7:0] TCC_RST_COUNT_HI = 8'h00;
    localparam logic [7:0] TCC_RST_COUNT_LO = 8'h01;
    localparam logic [7:0] TCC_RST_RELOAD_HI = 8'hFF;
    localparam logic [7:0] TCC_RST_RELOAD_LO = 8'hFF;
    localparam logic [7:0] TCC_RST_CAPTURE = 8'h00;
    localparam logic [7:0] TCC_RST_CONTROL = 8'h00;
    localparam logic [15:0] TCC_COUNT_START = 16'h0001;

    // Control register fields
    localparam int TCC_CTL_ENABLE_BIT = 7;
    localparam int TCC_CTL_POLARITY_BIT = 6;
    localparam int TCC_CTL_PRESCALE_LSB = 3;
    // Control-one fields
    localparam int TCC_CT1_CAUSE_BIT = 3;
    localparam int TCC_CT1_IRQSEL_LSB = 6;

    localparam logic [1:0] TCC_IRQ_BOTH = 2'h0;
    localparam logic [1:0] TCC_IRQ_CAPTURE = 2'h2;
    localparam logic [1:0] TCC_IRQ_RELOAD = 2'h3;
endpackage

/* File: logic/tcc_timer.sv */
/*
 Capture/compare timer with a byte register port.
 Assumes timer_in is synchronous to clk_sys and toggles at no more than
 a quarter of its rate; irq_req is taken by an outside interrupt controller.
*/
// Summary of operation
// - Interrupts on capture and reload by default; selectable to either alone.
// - Count low byte resets to 01h and is read/write.
// - Reload high byte resets to FFh.
// - Reload low byte resets to FFh and is read/write.
// - Capture high byte resets to zero and is read/write.
// - Enabled timer waits for first selected edge, then counts prescaled clocks.
// - Later edges capture count, interrupt, set cause flag, restart at one.
// - Count reaching compare interrupts, clears cause flag, restarts at one.
`timescale 1ns/1ps
module tcc_timer
    import tcc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [11:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic timer_in,
    output logic irq_req
);
    logic [7:0] ctl_r;
    logic [7:0] ct1_r;
    logic [15:0] count_r;
    logic [15:0] reload_r;
    logic [15:0] capture_r;
    logic [1:0] sync_r;
    logic prev_r;
    logic started_r;
    logic [6:0] pre_r;
    logic edge_hit;
    logic tick;
    logic at_compare;
    logic cap_ev;
    logic cmp_ev;
    logic [2:0] pre_sel;
    logic [6:0] pre_max;

    assign pre_sel = ctl_r[TCC_CTL_PRESCALE_LSB +: 3];
    assign pre_max = 7'((8'h01 << pre_sel) - 8'h01);
    assign tick = (pre_r == pre_max);
    assign at_compare = (count_r == reload_r);
    assign edge_hit = ctl_r[TCC_CTL_POLARITY_BIT] ? (sync_r[1] & ~prev_r)
                                                  : (~sync_r[1] & prev_r);
    assign cap_ev = ctl_r[TCC_CTL_ENABLE_BIT] & started_r & edge_hit;
    assign cmp_ev = ctl_r[TCC_CTL_ENABLE_BIT] & started_r & ~edge_hit
                    & tick & at_compare;

    // Two-stage synchroniser, then edge detector on the second stage
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sync_r <= 2'h0;
            prev_r <= 1'b0;
        end
        else
        begin
            sync_r <= {sync_r[0], timer_in};
            prev_r <= sync_r[1];
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            started_r <= 1'b0;
        else if (!ctl_r[TCC_CTL_ENABLE_BIT])
            started_r <= 1'b0;
        else if (edge_hit)
            started_r <= 1'b1;
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            pre_r <= 7'h00;
        else if (!started_r || cap_ev || tick)
            pre_r <= 7'h00;
        else
            pre_r <= pre_r + 7'h01;
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            ctl_r <= TCC_RST_CONTROL;
        else if (reg_wr && reg_addr == TCC_ADDR_CONTROL)
            ctl_r <= reg_wdata;
    end

    // Hardware cause updates win over a software write in the same cycle
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            ct1_r <= TCC_RST_CONTROL;
        else
        begin
            if (reg_wr && reg_addr == TCC_ADDR_CONTROL_ONE)
                ct1_r <= reg_wdata;
            if (cap_ev)
                ct1_r[TCC_CT1_CAUSE_BIT] <= 1'b1;
            else if (cmp_ev)
                ct1_r[TCC_CT1_CAUSE_BIT] <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            count_r <= {TCC_RST_COUNT_HI, TCC_RST_COUNT_LO};
        else if (cap_ev || cmp_ev)
            count_r <= TCC_COUNT_START;
        else if (reg_wr && reg_addr == TCC_ADDR_COUNT_HI)
            count_r[15:8] <= reg_wdata;
        else if (reg_wr && reg_addr == TCC_ADDR_COUNT_LO)
            count_r[7:0] <= reg_wdata;
        else if (ctl_r[TCC_CTL_ENABLE_BIT] && started_r && tick)
            count_r <= count_r + 16'h0001;
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            reload_r <= {TCC_RST_RELOAD_HI, TCC_RST_RELOAD_LO};
        else if (reg_wr && reg_addr == TCC_ADDR_RELOAD_HI)
            reload_r[15:8] <= reg_wdata;
        else if (reg_wr && reg_addr == TCC_ADDR_RELOAD_LO)
            reload_r[7:0] <= reg_wdata;
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            capture_r <= {TCC_RST_CAPTURE, TCC_RST_CAPTURE};
        else if (cap_ev)
            capture_r <= count_r;
        else if (reg_wr && reg_addr == TCC_ADDR_CAPTURE_HI)
            capture_r[15:8] <= reg_wdata;
        else if (reg_wr && reg_addr == TCC_ADDR_CAPTURE_LO)
            capture_r[7:0] <= reg_wdata;
    end

    // One-cycle interrupt request pulse filtered by source select
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            irq_req <= 1'b0;
        else
        begin
            unique case (ct1_r[TCC_CT1_IRQSEL_LSB +: 2])
                TCC_IRQ_CAPTURE: irq_req <= cap_ev;
                TCC_IRQ_RELOAD: irq_req <= cmp_ev;
                default: irq_req <= cap_ev | cmp_ev;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            reg_rdata <= 8'h00;
        else if (reg_rd)
        begin
            unique case (reg_addr)
                TCC_ADDR_COUNT_HI: reg_rdata <= count_r[15:8];
                TCC_ADDR_COUNT_LO: reg_rdata <= count_r[7:0];
                TCC_ADDR_RELOAD_HI: reg_rdata <= reload_r[15:8];
                TCC_ADDR_RELOAD_LO: reg_rdata <= reload_r[7:0];
                TCC_ADDR_CAPTURE_HI: reg_rdata <= capture_r[15:8];
                TCC_ADDR_CAPTURE_LO: reg_rdata <= capture_r[7:0];
                TCC_ADDR_CONTROL: reg_rdata <= ctl_r;
                TCC_ADDR_CONTROL_ONE: reg_rdata <= ct1_r;
                default: reg_rdata <= 8'h00;
            endcase
        end
        else
            reg_rdata <= 8'h00;
    end

    a_count_restart: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (cap_ev || cmp_ev) |=> count_r == 16'h0001)
        else $error("count did not restart at one");
    a_capture_both: assert property (@(posedge clk_sys) disable iff (!rst_n)
        cap_ev |=> capture_r == $past(count_r))
        else $error("capture value inconsistent");
    a_cause_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
        cap_ev |=> ct1_r[TCC_CT1_CAUSE_BIT])
        else $error("cause flag not set on capture");
    a_cause_clr: assert property (@(posedge clk_sys) disable iff (!rst_n)
        cmp_ev |=> !ct1_r[TCC_CT1_CAUSE_BIT])
        else $error("cause flag not cleared on compare");
    a_irq_default: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (ct1_r[TCC_CT1_IRQSEL_LSB +: 2] == TCC_IRQ_BOTH && (cap_ev || cmp_ev))
        |=> irq_req)
        else $error("missing interrupt request");
    a_irq_capsel: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (ct1_r[TCC_CT1_IRQSEL_LSB +: 2] == TCC_IRQ_CAPTURE && !cap_ev)
        |=> !irq_req)
        else $error("interrupt outside capture selection");
    a_wait_first: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (!started_r && !(reg_wr && (reg_addr == TCC_ADDR_COUNT_HI
        || reg_addr == TCC_ADDR_COUNT_LO))) |=> $stable(count_r))
        else $error("counted before first edge");
    a_sync_edge: assert property (@(posedge clk_sys) disable iff (!rst_n)
        edge_hit |-> sync_r[1] != $past(sync_r[1]))
        else $error("edge not from synchronised input");
endmodule

/* File: test/tcc_src.sv */
/*
 External signal source on the timer input.
 Assumes the bench sets run and half just after clk_sys edges.
*/
`timescale 1ns/1ps
module tcc_src
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic run,
    input wire logic [7:0] half,
    output logic timer_in
);
    logic [7:0] cnt_r;
    // Half period of two or more keeps the input at or below a quarter of the clock
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_r <= 8'h00;
            timer_in <= 1'b0;
        end
        else if (run && cnt_r >= half - 8'h01)
        begin
            cnt_r <= 8'h00;
            timer_in <= ~timer_in;
        end
        else if (run)
        begin
            cnt_r <= cnt_r + 8'h01;
        end
    end
endmodule

/* File: test/timer_capture_compare_tb_top.sv */
/*
 Self-checking bench for the capture/compare timer.
 Assumes tcc_pkg, tcc_timer and the source model tcc_src.
*/
`timescale 1ns/1ps
module timer_capture_compare_tb_top
    import tcc_pkg::*;
;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic [11:0] reg_addr = 12'h000;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic src_run = 1'b0;
    logic [7:0] src_half = 8'h02;
    logic [7:0] reg_rdata;
    logic timer_in;
    logic irq_req;
    int n_mismatch = 0;
    int checks = 0;
    int n_irq = 0;
    int n_base = 0;
    int n_new;
    logic pol;
    logic [2:0] p;
    int cyc = 0;
    int t_prev = 0;
    int t_last = 0;
    logic [7:0] d;
    logic [15:0] rl;
    logic [7:0] h;
    logic [7:0] rst_v [4] = '{8'h01, 8'hFF, 8'hFF, 8'h00};
    logic [1:0] modes [3] = '{TCC_IRQ_BOTH, TCC_IRQ_CAPTURE, TCC_IRQ_RELOAD};

    tcc_timer DUT (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .timer_in(timer_in), .irq_req(irq_req));
    tcc_src SRC (.clk_sys(clk_sys), .rst_n(rst_n), .run(src_run), .half(src_half),
        .timer_in(timer_in));

    initial
    begin
        forever #5 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys)
    begin
        cyc <= cyc + 1;
        if (irq_req === 1'b1)
        begin
            n_irq <= n_irq + 1;
            t_prev <= t_last;
            t_last <= cyc;
        end
    end

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] v);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, output logic [7:0] v);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(negedge clk_sys);
        v = reg_rdata;
    endtask

    // Cause bit is preset opposite to what the scenario expects the timer to leave
    task automatic cfg(input logic [1:0] mode, input logic [15:0] cmp, input logic pol_sel,
        input logic cause, input logic [2:0] pre);
        wr(TCC_ADDR_CONTROL, {1'b0, pol_sel, pre, 3'h0});
        wr(TCC_ADDR_COUNT_HI, 8'h00);
        wr(TCC_ADDR_COUNT_LO, 8'h01);
        wr(TCC_ADDR_RELOAD_HI, cmp[15:8]);
        wr(TCC_ADDR_RELOAD_LO, cmp[7:0]);
        wr(TCC_ADDR_CONTROL_ONE, {mode, 2'h0, cause, 3'h0});
        n_base = n_irq;
        wr(TCC_ADDR_CONTROL, {1'b1, pol_sel, pre, 3'h0});
    endtask

    function automatic logic irq_on(input logic [1:0] mode, input logic cap);
        return cap ? (mode != TCC_IRQ_RELOAD) : (mode != TCC_IRQ_CAPTURE);
    endfunction

    task automatic summarize();
        if (n_mismatch == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge clk_sys);
        n_mismatch++;
        summarize();
    end

    initial
    begin
        void'($urandom(32'h1f8856a3));
        repeat (20) @(posedge clk_sys);
        rst_n <= 1'b1;
        for (int i = 0; i < 4; i++)
        begin
            rd(TCC_ADDR_COUNT_LO + 12'(i), d);
            chk("reset_value", {8'h00, rst_v[i]}, {8'h00, d});
            h = 8'($urandom);
            wr(TCC_ADDR_COUNT_LO + 12'(i), h);
            rd(TCC_ADDR_COUNT_LO + 12'(i), d);
            chk("read_write", {8'h00, h}, {8'h00, d});
        end
        rd(12'h0A5, d);
        chk("unmapped_read", 16'h0000, {8'h00, d});
        foreach (modes[m])
        begin
            h = 8'(2 + $urandom_range(18));
            pol = (m != 1);
            cfg(modes[m], 16'hFFFF, pol, 1'b0, 3'h0);
            src_half <= h;
            src_run <= 1'b1;
            repeat (8 * h + 30) @(posedge clk_sys);
            src_run <= 1'b0;
            repeat (10) @(posedge clk_sys);
            n_new = n_irq - n_base;
            chk("capture_irq", 16'(irq_on(modes[m], 1'b1)), 16'(n_new > 0));
            if (irq_on(modes[m], 1'b1))
                chk("capture_gap", 16'(2 * h), 16'(t_last - t_prev));
            rd(TCC_ADDR_CAPTURE_HI, rl[15:8]);
            rd(TCC_ADDR_CAPTURE_LO, rl[7:0]);
            chk("capture_value", 16'(2 * h), rl);
            rd(TCC_ADDR_CONTROL_ONE, d);
            chk("cause_set", 16'h0001, 16'(d[TCC_CT1_CAUSE_BIT]));
            rl = 16'(8 + $urandom_range(40));
            p = 3'($urandom_range(2));
            cfg(modes[m], rl, pol, 1'b1, p);
            repeat (60) @(posedge clk_sys);
            chk("idle_irq", 16'h0000, 16'(n_irq - n_base));
            // At most one unselected transition, then exactly one selected edge to start the count
            src_run <= 1'b1;
            while (timer_in !== ~pol) @(posedge clk_sys);
            while (timer_in !== pol) @(posedge clk_sys);
            src_run <= 1'b0;
            repeat (3 * (rl << p) + 20) @(posedge clk_sys);
            n_new = n_irq - n_base;
            chk("compare_irq", 16'(irq_on(modes[m], 1'b0)), 16'(n_new > 0));
            if (irq_on(modes[m], 1'b0))
                chk("compare_gap", 16'(rl << p), 16'(t_last - t_prev));
            rd(TCC_ADDR_CONTROL_ONE, d);
            chk("cause_clear", 16'h0000, 16'(d[TCC_CT1_CAUSE_BIT]));
        end
        summarize();
    end
endmodule
